// ### include/aca_pkg.sv
// ============================================================
// Constants and carriers for the auxiliary and access control
package aca_pkg;
    // Transfer selector fields
    localparam logic [3:0] ACA_CRN_C1 = 4'h1;
    localparam logic [3:0] ACA_CRM_C0 = 4'h0;
    localparam logic [2:0] ACA_OP2_AUX = 3'h1;
    localparam logic [2:0] ACA_OP2_CPAC = 3'h2;
    localparam logic [2:0] ACA_OP1_ZERO = 3'h0;

    // Auxiliary bit positions
    localparam int ACA_AUX_ALIAS = 0;
    localparam int ACA_AUX_L2_CACHE_ENABLE = 1;
    localparam int ACA_AUX_RSVD = 2;
    localparam int ACA_AUX_PAR = 3;
    localparam int ACA_AUX_SPEC = 4;
    localparam int ACA_AUX_VEC = 5;
    localparam int ACA_AUX_IBE = 6;
    localparam int ACA_AUX_BSZ = 7;
    localparam int ACA_AUX_LOW_W = 8;
    // Bits that secure privileged code may write, bit 1 handled apart
    localparam logic [7:0] ACA_AUX_SEC_MASK = 8'hf9;
    localparam logic [7:0] ACA_AUX_RESET = 8'h00;
    localparam logic ACA_L2_RESET = 1'b0;

    // Coprocessor access register
    localparam int ACA_NUM_CP = 14;
    localparam int ACA_FIELD_W = 2;
    localparam logic [1:0] ACA_RIGHT_DENIED = 2'h0;
    localparam logic [1:0] ACA_RIGHT_PRIV = 2'h1;
    localparam logic [1:0] ACA_RIGHT_RSVD = 2'h2;
    localparam logic [1:0] ACA_RIGHT_FULL = 2'h3;
    localparam logic [3:0] ACA_CP_DEBUG = 4'he;
    localparam logic [3:0] ACA_CP_SYSCTL = 4'hf;

    // One system-coprocessor transfer from the pipeline
    typedef struct packed {
        logic valid;
        logic write;
        logic [2:0] opc1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] opc2;
        logic [31:0] wdata;
    } aca_xfer_t;

    // Execution context of the issuing instruction
    typedef struct packed {
        logic privileged;
        logic nonsecure;
    } aca_ctx_t;

    // Coprocessor-use check request
    typedef struct packed {
        logic valid;
        logic [3:0] cp_num;
    } aca_cp_req_t;
endpackage : aca_pkg

// ### design/aca_field.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// One two-bit coprocessor rights field
module aca_field
    import aca_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Control
    input wire logic present,
    input wire logic wr_en,
    input wire logic [1:0] wr_val,
    // State
    output logic [1:0] field_r
);
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            field_r <= ACA_RIGHT_DENIED;
        end else if (!present) begin
            field_r <= ACA_RIGHT_DENIED;
        end else if (wr_en) begin
            field_r <= wr_val;
        end
    end
endmodule : aca_field
`default_nettype wire

// ### design/aca_check.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Combinational coprocessor-use permission check
module aca_check
    import aca_pkg::*;
(
    // Request
    input wire aca_cp_req_t req,
    input wire aca_ctx_t ctx,
    // Rights state
    input wire logic [2*ACA_NUM_CP-1:0] rights,
    input wire logic [ACA_NUM_CP-1:0] ns_access,
    // Result
    output logic deny
);
    logic [1:0] code;
    always_comb begin
        code = ACA_RIGHT_DENIED;
        deny = 1'b0;
        if (req.valid && req.cp_num < ACA_CP_DEBUG) begin
            code = rights[req.cp_num*ACA_FIELD_W +: ACA_FIELD_W];
            // Nonsecure code sees a hidden coprocessor as denied
            if (ctx.nonsecure && !ns_access[req.cp_num]) begin
                code = ACA_RIGHT_DENIED;
            end
            unique case (code)
                ACA_RIGHT_DENIED: deny = 1'b1;
                ACA_RIGHT_PRIV: deny = !ctx.privileged;
                ACA_RIGHT_RSVD: deny = 1'b1;
                ACA_RIGHT_FULL: deny = 1'b0;
            endcase
        end
        // Debug and system control coprocessors are not gated here
    end
endmodule : aca_check
`default_nettype wire

// ### design/aca_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Contract
// - Bit 7 set suppresses branch size mispredicts
// - Bit 6 enables branch buffer invalidate operations
// - Bit 5 caches vector data in level one
// - Bit 4 permits speculative main bus accesses
// - Bit 3 enables level one parity detection
// - Bit 1 level two enable, banked per state
// - Bit 0 set disables hardware alias checking
// - Secure writes all but reserved bit 2; nonsecure banked; user undefined
// - Selected by c1, c0, opcode2 1 or 2
// - Fourteen two-bit rights fields, top reserved
// - Denied or underprivileged coprocessor use is undefined
// - Debug and system coprocessors are unaffected
// - Shared access register, privileged only
// - Nonsecure hidden field reads zero, writes ignored
// - Absent coprocessor field stays denied
// - Presence input holds field at denied
module aca_ctrl
    import aca_pkg::*;
#(
    parameter int NUM_CP = ACA_NUM_CP
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Transfer port
    input wire aca_xfer_t xfer,
    input wire aca_ctx_t ctx,
    // Coprocessor-use check port
    input wire aca_cp_req_t cp_req,
    // Configuration inputs
    input wire logic [NUM_CP-1:0] coprocessor_present_in,
    input wire logic [NUM_CP-1:0] ns_access,
    // Transfer answer
    output logic [31:0] rdata_r,
    output logic rvalid_r,
    output logic xfer_undef_r,
    // Check answer
    output logic cp_undef_r,
    // Auxiliary controls
    output logic hw_bsz_mispredict_disable_r,
    output logic btb_invalidate_enable_r,
    output logic l1_vector_caching_r,
    output logic speculative_access_enable_r,
    output logic l1_parity_enable_r,
    output logic l2_cache_enable_r,
    output logic l1_hw_alias_disable_r
);
    // ============================================================
    // Decode
    logic sel_aux;
    logic sel_cpac;
    logic hit;
    logic user_undef;
    logic aux_wr;
    logic cpac_wr;

    assign sel_aux = xfer.opc1 == ACA_OP1_ZERO && xfer.crn == ACA_CRN_C1
                     && xfer.crm == ACA_CRM_C0 && xfer.opc2 == ACA_OP2_AUX;
    assign sel_cpac = xfer.opc1 == ACA_OP1_ZERO && xfer.crn == ACA_CRN_C1
                      && xfer.crm == ACA_CRM_C0 && xfer.opc2 == ACA_OP2_CPAC;
    assign hit = xfer.valid && (sel_aux || sel_cpac);
    assign user_undef = hit && !ctx.privileged;
    assign aux_wr = xfer.valid && sel_aux && xfer.write && ctx.privileged;
    assign cpac_wr = xfer.valid && sel_cpac && xfer.write
                     && ctx.privileged;

    // ============================================================
    // Auxiliary register, secure-only bits
    logic [ACA_AUX_LOW_W-1:0] aux_r;
    logic [ACA_AUX_LOW_W-1:0] aux_nxt;

    always_comb begin
        aux_nxt = (aux_r & ~ACA_AUX_SEC_MASK)
                  | (xfer.wdata[ACA_AUX_LOW_W-1:0] & ACA_AUX_SEC_MASK);
    end

    // Nonsecure writes reach only the banked bit; bit 2 never stores
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aux_r <= ACA_AUX_RESET;
        end else if (aux_wr && !ctx.nonsecure) begin
            aux_r <= aux_nxt;
        end
    end

    // ============================================================
    // Banked level two enable, one copy per security state
    logic l2_sec_r;
    logic l2_ns_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            l2_sec_r <= ACA_L2_RESET;
        end else if (aux_wr && !ctx.nonsecure) begin
            l2_sec_r <= xfer.wdata[ACA_AUX_L2_CACHE_ENABLE];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            l2_ns_r <= ACA_L2_RESET;
        end else if (aux_wr && ctx.nonsecure) begin
            l2_ns_r <= xfer.wdata[ACA_AUX_L2_CACHE_ENABLE];
        end
    end

    // ============================================================
    // Coprocessor rights fields
    logic [2*NUM_CP-1:0] rights;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CP; gi++) begin : g_field
            logic fld_wr;
            // Hidden field ignores nonsecure writes
            assign fld_wr = cpac_wr && !(ctx.nonsecure && !ns_access[gi]);
            aca_field u_field (
                .core_clk(core_clk),
                .rstn(rstn),
                .present(coprocessor_present_in[gi]),
                .wr_en(fld_wr),
                .wr_val(xfer.wdata[gi*ACA_FIELD_W +: ACA_FIELD_W]),
                .field_r(rights[gi*ACA_FIELD_W +: ACA_FIELD_W])
            );
        end
    endgenerate

    // Read view masks fields hidden from nonsecure code
    logic [2*NUM_CP-1:0] rights_view;
    generate
        for (gi = 0; gi < NUM_CP; gi++) begin : g_view
            assign rights_view[gi*ACA_FIELD_W +: ACA_FIELD_W] =
                (ctx.nonsecure && !ns_access[gi]) ? ACA_RIGHT_DENIED
                : rights[gi*ACA_FIELD_W +: ACA_FIELD_W];
        end
    endgenerate

    // ============================================================
    // Read data
    logic [31:0] aux_view;
    logic [31:0] rd_nxt;

    always_comb begin
        aux_view = '0;
        aux_view[ACA_AUX_LOW_W-1:0] = aux_r & ACA_AUX_SEC_MASK;
        aux_view[ACA_AUX_L2_CACHE_ENABLE] = ctx.nonsecure ? l2_ns_r : l2_sec_r;
        rd_nxt = '0;
        if (sel_aux) begin
            rd_nxt = aux_view;
        end else if (sel_cpac) begin
            rd_nxt[2*NUM_CP-1:0] = rights_view;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= hit && !xfer.write && ctx.privileged;
            if (hit && !xfer.write && ctx.privileged) begin
                rdata_r <= rd_nxt;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            xfer_undef_r <= 1'b0;
        end else begin
            xfer_undef_r <= user_undef;
        end
    end

    // ============================================================
    // Coprocessor-use check
    logic cp_deny;

    aca_check u_check (
        .req(cp_req),
        .ctx(ctx),
        .rights(rights),
        .ns_access(ns_access),
        .deny(cp_deny)
    );

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cp_undef_r <= 1'b0;
        end else begin
            cp_undef_r <= cp_deny;
        end
    end

    // ============================================================
    // Control outputs, registered copies of the stored bits
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hw_bsz_mispredict_disable_r <= 1'b0;
            btb_invalidate_enable_r <= 1'b0;
            l1_vector_caching_r <= 1'b0;
            speculative_access_enable_r <= 1'b0;
            l1_parity_enable_r <= 1'b0;
            l1_hw_alias_disable_r <= 1'b0;
        end else begin
            hw_bsz_mispredict_disable_r <= aux_r[ACA_AUX_BSZ];
            btb_invalidate_enable_r <= aux_r[ACA_AUX_IBE];
            l1_vector_caching_r <= aux_r[ACA_AUX_VEC];
            speculative_access_enable_r <= aux_r[ACA_AUX_SPEC];
            l1_parity_enable_r <= aux_r[ACA_AUX_PAR];
            l1_hw_alias_disable_r <= aux_r[ACA_AUX_ALIAS];
        end
    end

    // Active copy follows the current security state
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            l2_cache_enable_r <= 1'b0;
        end else begin
            l2_cache_enable_r <= ctx.nonsecure ? l2_ns_r : l2_sec_r;
        end
    end
endmodule : aca_ctrl
`default_nettype wire

// ### verif/aca_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port checks of the control block
module aca_ctrl_monitor
    import aca_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Requests
    input wire aca_xfer_t xfer,
    input wire aca_ctx_t ctx,
    input wire aca_cp_req_t cp_req,
    input wire logic [13:0] coprocessor_present_in,
    input wire logic [13:0] ns_access,
    // Answers
    input wire logic [31:0] rdata_r,
    input wire logic rvalid_r,
    input wire logic xfer_undef_r,
    input wire logic cp_undef_r,
    input wire logic hw_bsz_mispredict_disable_r,
    input wire logic l1_parity_enable_r,
    input wire logic l1_hw_alias_disable_r
);
    logic aux, cpac, hit, cp_lo;
    logic [2:0] ctl;
    assign aux = xfer.opc2 == ACA_OP2_AUX;
    assign cpac = xfer.opc2 == ACA_OP2_CPAC;
    assign hit = xfer.valid && xfer.opc1 == ACA_OP1_ZERO &&
        xfer.crn == ACA_CRN_C1 && xfer.crm == ACA_CRM_C0 && (aux || cpac);
    assign cp_lo = cp_req.valid && cp_req.cp_num < 4'he;
    assign ctl = {hw_bsz_mispredict_disable_r, l1_parity_enable_r,
        l1_hw_alias_disable_r};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_rd;
        hit && !xfer.write && ctx.privileged;
    endsequence
    sequence s_aux_wr;
        hit && aux && xfer.write && ctx.privileged;
    endsequence
    // ============================================================
    // Transfer port
    AST_USER_UNDEF: assert property (
        hit && !ctx.privileged |=> xfer_undef_r && !rvalid_r)
        else $error("user access not refused");
    AST_READ_ANSWER: assert property (s_rd |=>
        rvalid_r && !xfer_undef_r) else $error("read not answered");
    AST_MISS_QUIET: assert property (
        !(hit && !(xfer.write && ctx.privileged)) |=>
        !rvalid_r && !xfer_undef_r) else $error("answer without hit");
    AST_TOP_ZERO: assert property (s_rd ##0 cpac |=>
        rdata_r[31:28] == 4'h0) else $error("reserved rights bits set");
    AST_BIT2_ZERO: assert property (s_rd ##0 aux |=>
        !rdata_r[2]) else $error("reserved aux bit set");
    AST_AUX_LAG: assert property (
        s_aux_wr ##0 !ctx.nonsecure |->
        ##2 ctl == {$past(xfer.wdata[7], 2), $past(xfer.wdata[3], 2),
        $past(xfer.wdata[0], 2)}) else $error("aux control wrong");
    AST_NS_KEEP: assert property (s_aux_wr ##0 ctx.nonsecure |->
        ##2 $stable(ctl)) else $error("nonsecure write changed aux");
    // ============================================================
    // Coprocessor-use check
    AST_CP_SYS: assert property (cp_req.valid && !cp_lo |=>
        !cp_undef_r) else $error("system coprocessor denied");
    AST_CP_ABSENT: assert property (
        cp_lo && !coprocessor_present_in[cp_req.cp_num] &&
        $stable(coprocessor_present_in) |=> cp_undef_r)
        else $error("absent coprocessor allowed");
    AST_CP_NS_HIDE: assert property (cp_lo && ctx.nonsecure &&
        !ns_access[cp_req.cp_num] |=> cp_undef_r)
        else $error("hidden coprocessor allowed");
    AST_CP_IDLE: assert property (!cp_req.valid |=>
        !cp_undef_r) else $error("deny without request");
endmodule : aca_ctrl_monitor
`default_nettype wire

// ### verif/aca_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module aca_ctrl_tb_top
    import aca_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    aca_xfer_t xfer = '0;
    aca_ctx_t ctx = '0;
    aca_cp_req_t cp_req = '0;
    logic [13:0] present = 14'h0c00;
    logic [13:0] nsa = 14'h0401;
    logic [31:0] rdata_r;
    logic rvalid_r, xfer_undef_r, cp_undef_r;
    wire logic [6:0] ao;
    int n_fail = 0;
    int n_tests = 0;
    // Columns: coprocessor, privileged, nonsecure, expected deny
    logic [6:0] tbl [7] = '{{4'ha, 3'b101}, {4'hb, 3'b100}, {4'hb, 3'b001},
        {4'hb, 3'b111}, {4'h0, 3'b101}, {4'he, 3'b010}, {4'hf, 3'b000}};
    always #25 core_clk = ~core_clk;
    aca_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .xfer(xfer),
        .ctx(ctx), .cp_req(cp_req), .coprocessor_present_in(present),
        .ns_access(nsa), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
        .xfer_undef_r(xfer_undef_r), .cp_undef_r(cp_undef_r),
        .hw_bsz_mispredict_disable_r(ao[6]), .btb_invalidate_enable_r(ao[5]),
        .l1_vector_caching_r(ao[4]), .speculative_access_enable_r(ao[3]),
        .l1_parity_enable_r(ao[2]), .l2_cache_enable_r(ao[1]),
        .l1_hw_alias_disable_r(ao[0]));
    // ============================================================
    // Access tasks, entered just after a rising edge
    task automatic xop(input logic wr, input logic [2:0] op2,
        input logic [31:0] d, input logic pr, input logic ns);
        // An idle edge first, so valid is never lowered and raised at once
        @(posedge core_clk);
        #1;
        xfer = '{1'b1, wr, ACA_OP1_ZERO, ACA_CRN_C1, ACA_CRM_C0, op2, d};
        ctx = '{pr, ns};
        @(posedge core_clk);
        #1;
        xfer.valid = 1'b0;
    endtask : xop
    task automatic rd(input logic [2:0] op2, input logic pr, input logic ns);
        xop(1'b0, op2, 32'h0, pr, ns);
        `CHK({rvalid_r, xfer_undef_r}, {pr, ~pr})
    endtask : rd
    task automatic cpchk(input logic [6:0] t);
        @(posedge core_clk);
        #1;
        cp_req = '{1'b1, t[6:3]};
        ctx = '{t[2], t[1]};
        @(posedge core_clk);
        #1;
        cp_req.valid = 1'b0;
        `CHK(cp_undef_r, t[0])
    endtask : cpchk
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    // ============================================================
    // Main sequence
    initial begin
        repeat (2) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        rd(ACA_OP2_AUX, 1'b1, 1'b0);
        `CHK(rdata_r[7:0], ACA_AUX_RESET)
        `CHK(ao[6:3], 4'h0)
        `CHK(ao[2:0], 3'h0)
        rd(ACA_OP2_CPAC, 1'b1, 1'b0);
        `CHK(rdata_r, 32'h0)
        $display("test reset done");
        xop(1'b1, ACA_OP2_AUX, 32'hff, 1'b1, 1'b0);
        rd(ACA_OP2_AUX, 1'b1, 1'b0);
        `CHK(rdata_r[7:0], 8'hfb)
        `CHK(ao[6:3], 4'hf)
        `CHK(ao[2:0], 3'h7)
        xop(1'b1, ACA_OP2_AUX, 32'h0, 1'b1, 1'b1);
        rd(ACA_OP2_AUX, 1'b1, 1'b1);
        `CHK(rdata_r[7:0], 8'hf9)
        `CHK(ao, 7'h7d)
        xop(1'b1, ACA_OP2_AUX, 32'h2, 1'b1, 1'b1);
        xop(1'b1, ACA_OP2_AUX, 32'h0, 1'b1, 1'b0);
        rd(ACA_OP2_AUX, 1'b1, 1'b0);
        `CHK(rdata_r[7:0], 8'h00)
        rd(ACA_OP2_AUX, 1'b1, 1'b1);
        `CHK(rdata_r[7:0], 8'h02)
        xop(1'b1, ACA_OP2_AUX, 32'hff, 1'b0, 1'b0);
        `CHK(xfer_undef_r, 1'b1)
        rd(ACA_OP2_AUX, 1'b0, 1'b1);
        rd(ACA_OP2_AUX, 1'b1, 1'b0);
        `CHK(rdata_r[7:0], 8'h00)
        // Set one control bit and keep the rest as read
        xop(1'b1, ACA_OP2_AUX, rdata_r | 32'h10, 1'b1, 1'b0);
        rd(ACA_OP2_AUX, 1'b1, 1'b0);
        `CHK(rdata_r[7:0], 8'h10)
        `CHK(ao[3], 1'b1)
        xop(1'b0, 3'h3, 32'h0, 1'b1, 1'b0);
        `CHK({rvalid_r, xfer_undef_r}, 2'b00)
        $display("test aux done");
        xop(1'b1, ACA_OP2_CPAC, 32'hffffffff, 1'b1, 1'b0);
        rd(ACA_OP2_CPAC, 1'b1, 1'b0);
        `CHK(rdata_r, 32'h00f00000)
        rd(ACA_OP2_CPAC, 1'b1, 1'b1);
        `CHK(rdata_r, 32'h00300000)
        xop(1'b1, ACA_OP2_CPAC, 32'h0, 1'b1, 1'b1);
        rd(ACA_OP2_CPAC, 1'b1, 1'b0);
        `CHK(rdata_r, 32'h00c00000)
        rd(ACA_OP2_CPAC, 1'b0, 1'b0);
        xop(1'b1, ACA_OP2_CPAC, 32'h00600003, 1'b1, 1'b0);
        rd(ACA_OP2_CPAC, 1'b1, 1'b0);
        `CHK(rdata_r, 32'h00600000)
        $display("test rights done");
        // Idle edges stand in for the barrier after a rights update
        repeat (2) @(posedge core_clk);
        for (int i = 0; i < 7; i++) begin
            cpchk(tbl[i]);
        end
        xop(1'b1, ACA_OP2_CPAC, 32'h00c00000, 1'b1, 1'b0);
        repeat (2) @(posedge core_clk);
        cpchk({4'hb, 3'b000});
        cpchk({4'ha, 3'b101});
        $display("test use done");
        finish_test();
    end
endmodule : aca_ctrl_tb_top
bind aca_ctrl aca_ctrl_monitor u_mon (.core_clk(core_clk), .rstn(rstn),
    .xfer(xfer), .ctx(ctx), .cp_req(cp_req),
    .coprocessor_present_in(coprocessor_present_in), .ns_access(ns_access),
    .rdata_r(rdata_r), .rvalid_r(rvalid_r), .xfer_undef_r(xfer_undef_r),
    .cp_undef_r(cp_undef_r),
    .hw_bsz_mispredict_disable_r(hw_bsz_mispredict_disable_r),
    .l1_parity_enable_r(l1_parity_enable_r),
    .l1_hw_alias_disable_r(l1_hw_alias_disable_r));
`default_nettype wire
